// ===== rtl/icu_pkg.sv
// Constants, field layouts and mode codes for the input capture unit
// What this block does
// RULE1: Modes 011/010/100/101 pick capture edges
// RULE2: Mode 001 captures both edges, ignores ratio
// RULE3: Mode 111: sleep/idle rising-edge interrupt only
// RULE4: Modes 000 and 110 disable the module
// RULE5: Ratio field interrupts every 1-4 captures
// RULE6: Time-base select picks counter clock source
// RULE7: Idle-stop bit halts module in idle
// RULE8: Read-only overflow flag reports lost capture
// RULE9: Not-empty flag tracks unread FIFO data
// RULE10: Software disables source, drains FIFO first
// RULE11: Cascade bit in both forms 32 bits
// RULE12: Software reads odd low, even high
// RULE13: Software enables even cascade bit first
// RULE14: Software programs both modules identically, even first
// RULE15: Even module trigger-select clear, follows odd
// RULE16: Odd module fields govern cascaded operation
// RULE17: Cascaded sync held until source enabled
// RULE18: Trigger-select chooses trigger or sync
// RULE19: Trigger status set by hardware, holds clear
// RULE20: Five-bit source select, resets to 01101
// RULE21: Analog sources used only as triggers
// RULE22: Never trigger module from itself
// RULE23: Counter wraps, capture stores counter value
// RULE24: FIFO holds four captured values
// RULE25: Sync resets counter, trigger waits
// RULE26: Source zero plus trigger means software trigger
// RULE27: Capture into full FIFO sets overflow
// RULE28: Odd counter wrap increments even counter
package icu_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
  localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
  localparam logic [1:0] ADDR_FIFO_RD  = 2'h2;
  localparam logic [1:0] ADDR_COUNTER  = 2'h3;
  // Control one field positions
  localparam int IDLE_STOP_BIT  = 13;
  localparam int TSEL_LSB       = 10;
  localparam int IRQ_RATIO_LSB  = 5;
  localparam int OVERFLOW_BIT   = 4;
  localparam int NOT_EMPTY_BIT  = 3;
  localparam int MODE_LSB       = 0;
  // Control two field positions
  localparam int CASCADE_BIT    = 8;
  localparam int TRIG_SEL_BIT   = 7;
  localparam int TRIG_STAT_BIT  = 6;
  localparam int SYNC_SEL_LSB   = 0;
  // Reset values
  localparam logic [4:0]  SYNC_SEL_RESET = 5'h0D;
  localparam logic [15:0] COUNTER_MAX    = 16'hFFFF;
  localparam logic [15:0] COUNTER_ZERO   = 16'h0000;
  localparam logic [4:0]  SYNC_OFF       = 5'h00;
  // Prescaler terminal counts for every 4th and 16th edge
  localparam logic [3:0]  PRESCALE_4TH   = 4'h3;
  localparam logic [3:0]  PRESCALE_16TH  = 4'hF;
  // FIFO depth
  localparam int FIFO_DEPTH = 4;
  // Capture mode codes
  typedef enum logic [2:0] {
    MODE_OFF     = 3'b000,
    MODE_BOTH    = 3'b001,
    MODE_FALL    = 3'b010,
    MODE_RISE    = 3'b011,
    MODE_RISE4   = 3'b100,
    MODE_RISE16  = 3'b101,
    MODE_UNUSED  = 3'b110,
    MODE_WAKEIRQ = 3'b111
  } icu_mode_t;
  // Time base select codes
  typedef enum logic [2:0] {
    TB_TIMER3 = 3'b000,
    TB_TIMER2 = 3'b001,
    TB_TIMER4 = 3'b010,
    TB_TIMER5 = 3'b011,
    TB_TIMER1 = 3'b100,
    TB_RSVD5  = 3'b101,
    TB_RSVD6  = 3'b110,
    TB_SYSCLK = 3'b111
  } icu_tbase_t;
endpackage

// ===== rtl/icu_capture_fifo.sv
// Four-entry capture value FIFO with overflow-free push
`timescale 1ns/10ps
module icu_capture_fifo (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Write side
  input  wire logic        push,
  input  wire logic [15:0] pushData,
  // Read side
  input  wire logic        pop,
  output logic [15:0]      headData,
  // Status
  output logic             full,
  output logic             empty,
  output logic [2:0]       count
);
  // Storage and pointers
  logic [15:0] mem_q [icu_pkg::FIFO_DEPTH];
  logic [1:0]  wrPtr_q;
  logic [1:0]  rdPtr_q;
  logic [2:0]  count_q;
  wire         doPush = push && !full;
  wire         doPop  = pop && !empty;

  // Status decode
  assign full     = (count_q == 3'(icu_pkg::FIFO_DEPTH)); // RULE24
  assign empty    = (count_q == 3'h0);
  assign count    = count_q;
  assign headData = mem_q[rdPtr_q];

  // Storage writes; data array needs no reset
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= pushData;
    end
  end

  // Pointer and occupancy update
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= 2'h0;
      rdPtr_q <= 2'h0;
      count_q <= 3'h0;
    end else begin
      wrPtr_q <= wrPtr_q + 2'(doPush);
      rdPtr_q <= rdPtr_q + 2'(doPop);
      count_q <= count_q + 3'(doPush) - 3'(doPop);
    end
  end
endmodule

// ===== rtl/icu_capture_unit.sv
// Input capture unit: time base, edge capture, FIFO, registers, cascade
`timescale 1ns/10ps
module icu_capture_unit (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [1:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic [15:0]      regRdData,
  // External capture pin
  input  wire logic        captureInputPin,
  // Time base ticks: bit0 Timer1 .. bit4 Timer5
  input  wire logic [4:0]  timerTicks,
  // Sync/trigger source events and enables, indexed by select code
  input  wire logic [31:0] syncEvents,
  input  wire logic [31:0] syncSrcOn,
  // CPU power state
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  // Cascade pairing
  input  wire logic        isOddModule,
  input  wire logic        partnerCascade,
  input  wire logic        cascCarryIn,
  input  wire logic        cascClearIn,
  input  wire logic        cascCaptureIn,
  output logic             cascCarryOut,
  output logic             cascClearOut,
  output logic             cascCaptureOut,
  output logic             cascadeOn,
  // Interrupt pulse
  output logic             captureIrq
);
  // Control one fields
  logic       idleStop_q;
  logic [2:0] tbSel_q;
  logic [1:0] irqRatio_q;
  logic [2:0] mode_q;
  // Control two fields
  logic       cascade_q;
  logic       trigSel_q;
  logic       trigger_status_bit_q;
  logic [4:0] sync_source_select_q;
  // Datapath state
  logic [15:0] counter_q;
  logic        pinPrev_q;
  logic [3:0]  presc_q;
  logic [1:0]  irqCnt_q;
  logic        overflow_q;
  logic        irq_q;
  logic [15:0] rdData_q;
  // FIFO status
  logic [15:0] fifoHead;
  logic        fifoFull;
  logic        fifoEmpty;
  logic [2:0]  fifoCount;

  // Selected time base tick; reserved codes never tick
  function automatic logic tickSelect(input logic [2:0] sel, input logic [4:0] t);
    unique case (icu_pkg::icu_tbase_t'(sel))
      icu_pkg::TB_TIMER1: tickSelect = t[0];
      icu_pkg::TB_TIMER2: tickSelect = t[1];
      icu_pkg::TB_TIMER3: tickSelect = t[2];
      icu_pkg::TB_TIMER4: tickSelect = t[3];
      icu_pkg::TB_TIMER5: tickSelect = t[4];
      icu_pkg::TB_SYSCLK: tickSelect = 1'b1;
      icu_pkg::TB_RSVD5,
      icu_pkg::TB_RSVD6:  tickSelect = 1'b0;
    endcase
  endfunction

  // Register access decode
  wire wrOne   = regWrEn && (regAddr == icu_pkg::ADDR_CTRL_ONE);
  wire wrTwo   = regWrEn && (regAddr == icu_pkg::ADDR_CTRL_TWO);
  wire rdFifo  = regRdEn && (regAddr == icu_pkg::ADDR_FIFO_RD);
  wire fifoPop = rdFifo && !fifoEmpty;

  // Cascade role; even half follows the odd half
  assign cascadeOn  = cascade_q && partnerCascade;              // RULE11
  wire   evenSlave  = cascadeOn && !isOddModule;
  // Even half runs in sync with odd whatever its own trigger bit
  wire   trigEff    = trigSel_q && !evenSlave;                  // RULE15

  // Mode decode
  wire modeOff  = (mode_q == icu_pkg::MODE_OFF) ||
                  (mode_q == icu_pkg::MODE_UNUSED);             // RULE4
  wire modeWake = (mode_q == icu_pkg::MODE_WAKEIRQ);            // RULE3
  wire halted   = idleStop_q && cpuIdle;                        // RULE7
  wire active   = !modeOff && !modeWake && !halted;

  // Source decode
  wire srcSel   = (sync_source_select_q != icu_pkg::SYNC_OFF);             // RULE20
  wire srcEvt   = srcSel && syncEvents[sync_source_select_q];
  wire srcOn    = syncSrcOn[sync_source_select_q];
  // Hardware trigger: source event in trigger mode
  wire hwTrig   = trigEff && srcEvt;                            // RULE18

  // Counter control for an independent or odd module
  wire ownHold  = modeOff || modeWake ||
                  (trigEff && !trigger_status_bit_q) ||                   // RULE19
                  (cascadeOn && !trigEff && srcSel && !srcOn);  // RULE17
  wire ownClr   = !trigEff && srcSel && srcEvt;                 // RULE25
  wire ownTick  = tickSelect(tbSel_q, timerTicks);              // RULE6
  // Even half takes hold, clear and count from the odd half
  wire cntClear = evenSlave ? cascClearIn : (ownHold || ownClr);
  wire cntTick  = (evenSlave ? cascCarryIn : ownTick) && !halted; // RULE28
  wire wrapNow  = cntTick && !cntClear && (counter_q == icu_pkg::COUNTER_MAX);

  // Edge detection on the synchronous capture pin
  wire pinRise  = captureInputPin && !pinPrev_q;
  wire pinFall  = !captureInputPin && pinPrev_q;
  wire prescEnd = (mode_q == icu_pkg::MODE_RISE4) ? (presc_q == icu_pkg::PRESCALE_4TH)
                                                  : (presc_q == icu_pkg::PRESCALE_16TH);
  wire prescMode = (mode_q == icu_pkg::MODE_RISE4) || (mode_q == icu_pkg::MODE_RISE16);

  // Capture event per mode
  logic ownCap;
  always_comb begin
    unique case (icu_pkg::icu_mode_t'(mode_q))
      icu_pkg::MODE_BOTH:   ownCap = pinRise || pinFall;        // RULE2
      icu_pkg::MODE_FALL:   ownCap = pinFall;                   // RULE1
      icu_pkg::MODE_RISE:   ownCap = pinRise;                   // RULE1
      icu_pkg::MODE_RISE4,
      icu_pkg::MODE_RISE16: ownCap = pinRise && prescEnd;       // RULE1
      icu_pkg::MODE_OFF,
      icu_pkg::MODE_UNUSED,
      icu_pkg::MODE_WAKEIRQ: ownCap = 1'b0;                     // RULE4
    endcase
  end
  // Even half captures when the odd half does
  wire capEvt   = evenSlave ? cascCaptureIn : (ownCap && active); // RULE16
  wire ovEvt    = capEvt && fifoFull;                           // RULE27

  // Interrupt decode: ratio count, both-edge mode, wake mode
  wire ratioHit = (irqCnt_q == irqRatio_q);                     // RULE5
  wire capIrq   = capEvt && !evenSlave &&
                  ((mode_q == icu_pkg::MODE_BOTH) || ratioHit); // RULE2
  wire wakeIrq  = modeWake && pinRise && (cpuIdle || cpuSleep); // RULE3

  // Cascade outputs toward the even half
  assign cascCarryOut   = wrapNow;                              // RULE28
  assign cascClearOut   = cntClear;
  assign cascCaptureOut = capEvt;
  assign captureIrq     = irq_q;
  assign regRdData      = rdData_q;

  // Read mux: control one shows overflow and not-empty live
  logic [15:0] ctrlOne;
  logic [15:0] ctrlTwo;
  logic [15:0] rdMux;
  always_comb begin
    ctrlOne = 16'h0000;
    ctrlOne[icu_pkg::IDLE_STOP_BIT] = idleStop_q;
    ctrlOne[icu_pkg::TSEL_LSB +: 3] = tbSel_q;
    ctrlOne[icu_pkg::IRQ_RATIO_LSB +: 2] = irqRatio_q;
    ctrlOne[icu_pkg::OVERFLOW_BIT] = overflow_q;                // RULE8
    ctrlOne[icu_pkg::NOT_EMPTY_BIT] = !fifoEmpty;               // RULE9
    ctrlOne[icu_pkg::MODE_LSB +: 3] = mode_q;
    ctrlTwo = 16'h0000;
    ctrlTwo[icu_pkg::CASCADE_BIT] = cascade_q;
    ctrlTwo[icu_pkg::TRIG_SEL_BIT] = trigSel_q;
    ctrlTwo[icu_pkg::TRIG_STAT_BIT] = trigger_status_bit_q;
    ctrlTwo[icu_pkg::SYNC_SEL_LSB +: 5] = sync_source_select_q;
    unique case (regAddr)
      icu_pkg::ADDR_CTRL_ONE: rdMux = ctrlOne;
      icu_pkg::ADDR_CTRL_TWO: rdMux = ctrlTwo;
      icu_pkg::ADDR_FIFO_RD:  rdMux = fifoEmpty ? 16'h0000 : fifoHead;
      icu_pkg::ADDR_COUNTER:  rdMux = counter_q;
    endcase
  end

  // Capture value store
  icu_capture_fifo u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .push     (capEvt),
    .pushData (counter_q),                                      // RULE23
    .pop      (fifoPop),
    .headData (fifoHead),
    .full     (fifoFull),
    .empty    (fifoEmpty),
    .count    (fifoCount)
  );

  // Software-written control fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idleStop_q <= 1'b0;
      tbSel_q    <= 3'h0;
      irqRatio_q <= 2'h0;
      mode_q     <= icu_pkg::MODE_OFF;
      cascade_q  <= 1'b0;
      trigSel_q  <= 1'b0;
      sync_source_select_q  <= icu_pkg::SYNC_SEL_RESET;                    // RULE20
    end else if (wrOne) begin
      idleStop_q <= regWrData[icu_pkg::IDLE_STOP_BIT];
      tbSel_q    <= regWrData[icu_pkg::TSEL_LSB +: 3];
      irqRatio_q <= regWrData[icu_pkg::IRQ_RATIO_LSB +: 2];
      mode_q     <= regWrData[icu_pkg::MODE_LSB +: 3];
    end else if (wrTwo) begin
      cascade_q  <= regWrData[icu_pkg::CASCADE_BIT];
      trigSel_q  <= regWrData[icu_pkg::TRIG_SEL_BIT];
      sync_source_select_q  <= regWrData[icu_pkg::SYNC_SEL_LSB +: 5];
    end
  end

  // Trigger status: hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trigger_status_bit_q <= 1'b0;
    end else if (hwTrig) begin
      trigger_status_bit_q <= 1'b1;                                       // RULE19
    end else if (wrTwo) begin
      trigger_status_bit_q <= regWrData[icu_pkg::TRIG_STAT_BIT];          // RULE26
    end
  end

  // Time base counter, wraps from all ones to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_q <= icu_pkg::COUNTER_ZERO;
    end else if (cntClear) begin
      counter_q <= icu_pkg::COUNTER_ZERO;                       // RULE25
    end else if (cntTick) begin
      counter_q <= counter_q + 16'h0001;                        // RULE23
    end
  end

  // Edge history and prescaler; a mode write restarts the prescaler
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_q <= 1'b0;
      presc_q   <= 4'h0;
    end else begin
      pinPrev_q <= captureInputPin;
      if (wrOne || !prescMode || !active) begin
        presc_q <= 4'h0;
      end else if (pinRise) begin
        presc_q <= prescEnd ? 4'h0 : presc_q + 4'h1;            // RULE1
      end
    end
  end

  // Capture ratio counter and registered interrupt pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqCnt_q <= 2'h0;
      irq_q    <= 1'b0;
    end else begin
      irq_q <= capIrq || wakeIrq;
      if (wrOne) begin
        irqCnt_q <= 2'h0;
      end else if (capEvt) begin
        irqCnt_q <= ratioHit ? 2'h0 : irqCnt_q + 2'h1;          // RULE5
      end
    end
  end

  // Overflow flag: set wins, cleared once the FIFO is drained
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= ovEvt || (overflow_q && !fifoEmpty);        // RULE27
    end
  end

  // Read data stands in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 16'h0000;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_rise_capture;
    !evenSlave && active && mode_q == icu_pkg::MODE_RISE && pinRise && !fifoFull
      |=> fifoCount == $past(fifoCount) + 3'h1 - 3'($past(fifoPop));
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rise capture lost"); // RULE1

  property p_both_edges;
    !evenSlave && active && mode_q == icu_pkg::MODE_BOTH && pinFall |-> capEvt && capIrq;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge mode missed"); // RULE2

  property p_wake_irq;
    modeWake && pinRise && cpuSleep |=> captureIrq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt missing"); // RULE3

  property p_off_no_push;
    modeOff && !evenSlave |-> !capEvt ##1 counter_q == icu_pkg::COUNTER_ZERO;
  endproperty
  a_off_no_push: assert property (p_off_no_push) else $error("disabled module active"); // RULE4

  property p_idle_halt;
    halted && !cntClear |=> $stable(counter_q);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("counter ran in idle"); // RULE7

  property p_overflow;
    capEvt && fifoFull |=> overflow_q && fifoCount == $past(fifoCount) - 3'($past(fifoPop));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // RULE27

  property p_not_empty_fall;
    $fell(ctrlOne[icu_pkg::NOT_EMPTY_BIT]) |-> $past(fifoPop) && $past(fifoCount) == 3'h1;
  endproperty
  a_not_empty_fall: assert property (p_not_empty_fall) else $error("not-empty fell"); // RULE9

  property p_wrap;
    counter_q == icu_pkg::COUNTER_MAX && cntTick && !cntClear
      |-> cascCarryOut ##1 counter_q == icu_pkg::COUNTER_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap wrong"); // RULE23

  property p_trig_hold;
    !evenSlave && trigEff && !trigger_status_bit_q && !hwTrig |=> counter_q == icu_pkg::COUNTER_ZERO;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("untriggered counter moved"); // RULE19

  property p_fifo_depth;
    fifoCount <= 3'(icu_pkg::FIFO_DEPTH);
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("fifo over depth"); // RULE24

  c_overflow:  cover property (ovEvt);
  c_irq_ratio: cover property (capIrq && irqRatio_q == 2'h3);
  c_wrap:      cover property (cascCarryOut);
  c_hw_trig:   cover property (hwTrig ##1 trigger_status_bit_q);
endmodule

// ===== tb/icu_pulse_src.sv
// Partner model: external pulse source on the capture pin
`timescale 1ns/10ps
module icu_pulse_src (
  // Clock
  input  wire logic clk_sys,
  // Capture pin, idles low
  output logic      pin
);
  initial pin = 1'b0;
  // One pulse; rising edges of back-to-back pulses lie hi+lo+1 apart
  // Keep hi and lo at 1 or more in edge-detect mode: an edge needs a cycle
  task automatic pulse(input int hi, input int lo);
    @(posedge clk_sys);
    pin <= 1'b1;
    repeat (hi) @(posedge clk_sys);
    pin <= 1'b0;
    repeat (lo) @(posedge clk_sys);
  endtask
endmodule

// ===== tb/test_input_capture_unit.sv
// Self-checking bench for the input capture unit
`timescale 1ns/10ps
module test_input_capture_unit;
  // Design inputs and outputs
  logic        clk_sys;
  logic        rst_n;
  logic [1:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [15:0] regRdData;
  logic        pin;
  logic [4:0]  timerTicks;
  logic [31:0] syncEvents;
  logic [31:0] syncSrcOn;
  logic        cpuIdle;
  logic        cpuSleep;
  logic        isOdd;
  logic        partnerCasc;
  logic        carryIn;
  logic        captIn;
  logic        clrIn;
  logic        carryOut;
  logic        captOut;
  logic        cascOn;
  logic        clrOut;
  logic        irq;
  // Bench state
  int          n_mismatch;
  int          checked;
  int          nIrq;
  int          nWrap;
  int          i;
  int          k;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] v [4];

  icu_capture_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .captureInputPin(pin), .timerTicks(timerTicks),
    .syncEvents(syncEvents), .syncSrcOn(syncSrcOn), .cpuIdle(cpuIdle),
    .cpuSleep(cpuSleep), .isOddModule(isOdd), .partnerCascade(partnerCasc),
    .cascCarryIn(carryIn), .cascClearIn(clrIn), .cascCaptureIn(captIn),
    .cascCarryOut(carryOut), .cascClearOut(clrOut), .cascCaptureOut(captOut),
    .cascadeOn(cascOn), .captureIrq(irq));
  icu_pulse_src u_src (.clk_sys(clk_sys), .pin(pin));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Interrupt pulse counter
  always @(posedge clk_sys) begin
    if (irq === 1'b1) nIrq <= nIrq + 1;
  end
  // Carry pulses toward the high half
  always @(posedge clk_sys) begin
    if (carryOut === 1'b1) nWrap <= nWrap + 1;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #(2_000_000);
    n_mismatch++;
    finish_test();
  end

  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [1:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr   <= ad;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [1:0] ad, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= ad;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask
  // Control one image
  function automatic logic [15:0] mk1(logic s, logic [2:0] t, logic [1:0] r, logic [2:0] m);
    mk1 = 16'h0000;
    mk1[icu_pkg::IDLE_STOP_BIT] = s;
    mk1[icu_pkg::TSEL_LSB +: 3] = t;
    mk1[icu_pkg::IRQ_RATIO_LSB +: 2] = r;
    mk1[icu_pkg::MODE_LSB +: 3] = m;
  endfunction
  // Control two image
  function automatic logic [15:0] mk2(logic c, logic t, logic s, logic [4:0] sel);
    mk2 = 16'h0000;
    mk2[icu_pkg::CASCADE_BIT] = c;
    mk2[icu_pkg::TRIG_SEL_BIT] = t;
    mk2[icu_pkg::TRIG_STAT_BIT] = s;
    mk2[icu_pkg::SYNC_SEL_LSB +: 5] = sel;
  endfunction
  // Expected interrupts for np pulses
  function automatic int expIrq(int m, int r, int np, logic slp);
    int caps;
    case (m)
      1: return 2 * np;
      2, 3: caps = np;
      4: caps = np / 4;
      5: caps = np / 16;
      7: return slp ? np : 0;
      default: caps = 0;
    endcase
    return caps / (r + 1);
  endfunction
  // Tick bit of each time-base code
  function automatic int tickBit(int c);
    case (c)
      0: return 2;
      1: return 1;
      2: return 3;
      3: return 4;
      default: return 0;
    endcase
  endfunction
  // Pulse train with draining reads, interrupt count compared
  task automatic irqCase(int m, int r, int np, logic slp, logic idl, logic stp);
    logic [15:0] d;
    @(posedge clk_sys);
    cpuSleep <= slp;
    cpuIdle  <= idl;
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(stp, 3'b111, 2'(r), 3'(m)));
    nIrq = 0;
    for (int p = 0; p < np; p++) begin
      u_src.pulse(2 + $urandom % 3, 2 + $urandom % 3);
      rd(icu_pkg::ADDR_FIFO_RD, d);
      rd(icu_pkg::ADDR_FIFO_RD, d);
    end
    repeat (4) @(posedge clk_sys);
    d = 16'((stp && idl) ? 0 : expIrq(m, r, np, slp));
    check(16'(nIrq), d);
    wr(icu_pkg::ADDR_CTRL_ONE, 16'h0000);
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h5908));
    n_mismatch = 0;
    checked = 0;
    nIrq = 0;
    nWrap = 0;
    rst_n = 1'b0;
    {regAddr, regWrData, regWrEn, regRdEn, carryIn, captIn, clrIn} = '0;
    {timerTicks, syncEvents, cpuIdle, cpuSleep, partnerCasc} = '0;
    syncSrcOn = '1;
    isOdd = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, empty FIFO read
    rd(icu_pkg::ADDR_CTRL_ONE, a);
    check(a, 16'h0000);
    rd(icu_pkg::ADDR_CTRL_TWO, a);
    check(a, 16'h000D);
    rd(icu_pkg::ADDR_FIFO_RD, a);
    check(a, 16'h0000);
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(0, 0, 0, 5'h00));
    // Each timer tick input drives its own code only; reserved codes never count
    for (i = 0; i < 7; i++) begin
      wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'(i), 0, 3'b011));
      rd(icu_pkg::ADDR_COUNTER, a);
      k = 1 + $urandom % 6;
      repeat (k) begin
        @(posedge clk_sys) timerTicks <= 5'h1F;
        @(posedge clk_sys) timerTicks <= 5'h1F & ~(5'h01 << tickBit(i));
      end
      @(posedge clk_sys) timerTicks <= 5'h00;
      repeat (2) @(posedge clk_sys);
      rd(icu_pkg::ADDR_COUNTER, b);
      check(b - a, (i < 5) ? 16'(k) : 16'h0000);
    end
    // Free running at system clock, long enough to wrap once
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'b111, 0, 3'b011));
    rd(icu_pkg::ADDR_COUNTER, a);
    k = 65530 + $urandom % 6;
    repeat (k) @(posedge clk_sys);
    rd(icu_pkg::ADDR_COUNTER, b);
    check(b - a, 16'(k + 2));
    check(16'(nWrap), 16'((int'(a) + k + 3) / 65536));
    // Five captures into four places: overflow, order, RO flags
    for (i = 0; i < 5; i++) u_src.pulse(3, 2);
    repeat (2) @(posedge clk_sys);
    rd(icu_pkg::ADDR_CTRL_ONE, a);
    check({14'h0000, a[4:3]}, 16'h0003);
    for (i = 0; i < 4; i++) rd(icu_pkg::ADDR_FIFO_RD, v[i]);
    for (i = 1; i < 4; i++) check(v[i] - v[i-1], 16'h0006);
    rd(icu_pkg::ADDR_FIFO_RD, a);
    check(a, 16'h0000);
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'b111, 0, 3'b011) | 16'h0018);
    rd(icu_pkg::ADDR_CTRL_ONE, a);
    check(a, mk1(0, 3'b111, 0, 3'b011));
    wr(icu_pkg::ADDR_CTRL_ONE, 16'h0000);
    // Every mode, ratios, sleep and idle
    for (i = 0; i < 8; i++) irqCase(i, 0, 16, 1'b0, 1'b0, 1'b0);
    irqCase(7, 0, 6, 1'b1, 1'b0, 1'b0);
    for (i = 1; i < 4; i++) irqCase(3, i, 12, 1'b0, 1'b0, 1'b0);
    irqCase(1, 3, 6, 1'b0, 1'b0, 1'b0);
    irqCase(3, 0, 6, 1'b0, 1'b1, 1'b1);
    irqCase(3, 0, 6, 1'b0, 1'b1, 1'b0);
    @(posedge clk_sys) cpuIdle <= 1'b0;
    // Software trigger: held clear until status set
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'b111, 0, 3'b011));
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(0, 1, 0, 5'h00));
    rd(icu_pkg::ADDR_COUNTER, a);
    check(a, 16'h0000);
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(0, 1, 1, 5'h00));
    rd(icu_pkg::ADDR_COUNTER, a);
    rd(icu_pkg::ADDR_COUNTER, b);
    check(b - a, 16'h0002);
    // Hardware trigger from source 13
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(0, 1, 0, 5'h0D));
    rd(icu_pkg::ADDR_COUNTER, a);
    check(a, 16'h0000);
    @(posedge clk_sys) syncEvents <= 32'h0000_2000;
    @(posedge clk_sys) syncEvents <= 32'h0000_0000;
    rd(icu_pkg::ADDR_CTRL_TWO, a);
    check({15'h0000, a[6]}, 16'h0001);
    rd(icu_pkg::ADDR_COUNTER, a);
    rd(icu_pkg::ADDR_COUNTER, b);
    check(b - a, 16'h0002);
    // Sync mode: source event clears the running counter
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(0, 0, 0, 5'h0D));
    repeat (40) @(posedge clk_sys);
    rd(icu_pkg::ADDR_COUNTER, a);
    check(16'(a >= 16'h0028), 16'h0001);
    @(posedge clk_sys) syncEvents <= 32'h0000_2000;
    @(posedge clk_sys) syncEvents <= 32'h0000_0000;
    rd(icu_pkg::ADDR_COUNTER, a);
    check(16'(a < 16'h0008), 16'h0001);
    // Even module of a pair: counts odd carries, captures with odd
    @(posedge clk_sys);
    isOdd <= 1'b0;
    partnerCasc <= 1'b1;
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(1, 0, 0, 5'h00));
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'b111, 0, 3'b000));
    check(16'(cascOn), 16'h0001);
    nIrq = 0;
    rd(icu_pkg::ADDR_COUNTER, a);
    repeat (3) begin
      @(posedge clk_sys) carryIn <= 1'b1;
      @(posedge clk_sys) carryIn <= 1'b0;
    end
    rd(icu_pkg::ADDR_COUNTER, b);
    check(b - a, 16'h0003);
    @(posedge clk_sys) captIn <= 1'b1;
    #1 check(16'(captOut), 16'h0001);
    @(posedge clk_sys) captIn <= 1'b0;
    rd(icu_pkg::ADDR_CTRL_ONE, a);
    check({15'h0000, a[3]}, 16'h0001);
    rd(icu_pkg::ADDR_FIFO_RD, a);
    check(a, b);
    check(16'(nIrq), 16'h0000);
    @(posedge clk_sys) clrIn <= 1'b1;
    @(posedge clk_sys) clrIn <= 1'b0;
    rd(icu_pkg::ADDR_COUNTER, a);
    check(a, 16'h0000);
    @(posedge clk_sys) partnerCasc <= 1'b0;
    @(posedge clk_sys);
    check(16'(cascOn), 16'h0000);
    // Odd module, cascaded sync: held until the source is on
    @(posedge clk_sys);
    isOdd <= 1'b1;
    partnerCasc <= 1'b1;
    syncSrcOn <= 32'h0000_0000;
    wr(icu_pkg::ADDR_CTRL_TWO, mk2(1, 0, 0, 5'h0D));
    wr(icu_pkg::ADDR_CTRL_ONE, mk1(0, 3'b111, 0, 3'b011));
    rd(icu_pkg::ADDR_COUNTER, a);
    check(a, 16'h0000);
    check(16'(clrOut), 16'h0001);
    @(posedge clk_sys) syncSrcOn <= 32'hFFFF_FFFF;
    rd(icu_pkg::ADDR_COUNTER, a);
    rd(icu_pkg::ADDR_COUNTER, b);
    check(b - a, 16'h0002);
    finish_test();
  end
endmodule
